// >>> include/csfr_defs.vh
// Constants for the core status flag register block.
// Assumes inclusion by bare name from the design file.
`ifndef CSFR_DEFS_VH
`define CSFR_DEFS_VH

// ****************************************
// APB register byte addresses
// ****************************************
`define CSFR_ADDR_STATUS    12'h000
`define CSFR_ADDR_PRESCALE  12'h004
`define CSFR_ADDR_RESULT    12'h008

// ****************************************
// Status register field positions
// ****************************************
`define CSFR_BIT_CARRY      0
`define CSFR_BIT_NIBBLE     1
`define CSFR_BIT_ZERO       2
`define CSFR_BIT_SLEEP      3
`define CSFR_BIT_WDOG       4
`define CSFR_BIT_DBANK_LO   5
`define CSFR_BIT_DBANK_HI   6
`define CSFR_BIT_IBANK      7

// ****************************************
// Reset values
// ****************************************
`define CSFR_RST_BANKS      3'h0
`define CSFR_RST_ALUFLAGS   3'h0
`define CSFR_RST_PRESCALE   4'hF

// ****************************************
// Prescaler config fields
// ****************************************
`define CSFR_BIT_OWNER      3

// ****************************************
// ALU operation kinds
// ****************************************
`define CSFR_OP_NONE        3'h0
`define CSFR_OP_LOGIC       3'h1
`define CSFR_OP_ADD         3'h2
`define CSFR_OP_SUB         3'h3
`define CSFR_OP_ROTL        3'h4
`define CSFR_OP_ROTR        3'h5

`endif

// >>> rtl/csfr_status_reg.v
// Status flag register of an 8-bit core, with ALU flag logic,
// bank-select address forming and the shared timer/watchdog prescaler.
// Assumes one clock, synchronous active-high reset, APB master outside.
// Instruction-side strobes are single-cycle and already decoded.
// Prescaler count restarts on every configuration write.
// Undefined-at-power-on flags are simply cleared by reset.
//
// How it works
// - Status register writable as instruction destination
// - Flag-affecting instruction overrides written flag bits
// - Watchdog and sleep flags read-only, reset one
// - Zero-instruction clears banks, sets zero flag
// - Subtract carries are inverted borrows
// - Indirect bank bit is ninth address bit
// - Direct bank bits select one of four banks
// - Sleep flag set by kick, cleared by sleep
// - Zero flag follows zero result
// - Nibble flag is carry out of bit three
// - Carry flag is carry out of top bit
// - Banks reset clear; six bits read/write
// - Owner bit one gives timer 1:1 rate
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "csfr_defs.vh"
`default_nettype none

module csfr_status_reg (
    input  wire        i_mclk,         // Core clock
    input  wire        i_srst,         // Sync reset, high
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Instruction side
    input  wire        i_core_wr,      // Instruction stores to status
    input  wire [7:0]  i_core_wdata,   // Value stored
    input  wire        i_clr_status,   // Zero-instruction on status
    input  wire [2:0]  i_alu_op,       // Operation kind
    input  wire [7:0]  i_alu_a,        // First operand
    input  wire [7:0]  i_alu_b,        // Second operand
    input  wire        i_wdt_kick,     // Watchdog kick instruction
    input  wire        i_sleep,        // Sleep instruction
    input  wire        i_wdt_timeout,  // Watchdog time-out event
    // Address forming
    input  wire [6:0]  i_dir_addr,     // Direct address field
    input  wire [7:0]  i_ind_ptr,      // Indirect pointer
    output reg  [8:0]  o_dir_addr,     // Full direct address
    output reg  [8:0]  o_ind_addr,     // Full indirect address
    // Flags and result
    output reg  [7:0]  o_status,       // Status register
    output reg  [7:0]  o_alu_result,   // Last ALU result
    // Prescaler
    input  wire        i_tmr0_tick,    // Timer-zero source tick
    input  wire        i_wdt_tick,     // Watchdog oscillator tick
    output reg         o_tmr0_step,    // Timer-zero increment pulse
    output reg         o_wdt_step      // Watchdog increment pulse
);

    // ****************************************
    // Helpers
    // ****************************************

    // True when every bit below bit n of the count is one
    // Rate zero on the watchdog side gives an empty mask, so every tick passes
    // Shared by both prescaler directions
    function ripe;
        input [7:0] cnt;
        input [3:0] n;
        reg   [8:0] mask;
        begin
            mask = (9'h001 << n) - 9'h001;
            ripe = ((cnt & mask[7:0]) == mask[7:0]);
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg  [7:0] status_q;               // Status bits
    reg  [7:0] status_d;
    reg  [7:0] result_q;               // ALU result
    reg  [7:0] result_d;
    reg  [3:0] pscfg_q;                // Owner bit and rate
    reg  [7:0] pscnt_q;                // Shared prescaler count
    reg        pready_q;               // APB ready
    reg  [31:0] prdata_q;              // APB read data
    reg        pslverr_q;              // APB error

    // Bus decode; a transfer completes when ready stands in access
    // Only full word addresses match, low bits included
    wire       apb_acc = i_psel & i_penable;
    wire       apb_done = apb_acc & pready_q;
    wire       apb_wr = apb_done & i_pwrite;
    wire       hit_st = (i_paddr == `CSFR_ADDR_STATUS);
    wire       hit_ps = (i_paddr == `CSFR_ADDR_PRESCALE);
    wire       hit_rs = (i_paddr == `CSFR_ADDR_RESULT);
    wire       hit_any = hit_st | hit_ps | hit_rs;
    // Prescaler configuration fields
    wire       owner = pscfg_q[`CSFR_BIT_OWNER];
    wire [2:0] rate = pscfg_q[2:0];

    // ****************************************
    // ALU flags
    // ****************************************
    reg  [8:0] wide;                   // Result with carry out
    reg  [4:0] low;                    // Low nibble with carry out
    reg        upd_z;                  // Zero flag updated
    reg        upd_c;                  // Carry flag updated
    reg        upd_dc;                 // Nibble flag updated

    // Result and flag sources for each kind
    // Nine-bit sum keeps the carry out of bit seven
    // Subtract adds the inverted operand plus one, so carry is no-borrow
    // Rotates pull the old carry in and push the leaving bit out
    always @* begin
        wide   = 9'h000;
        low    = 5'h00;
        upd_z  = 1'b0;
        upd_c  = 1'b0;
        upd_dc = 1'b0;
        case (i_alu_op)
            `CSFR_OP_LOGIC: begin
                wide  = {1'b0, i_alu_a};
                upd_z = 1'b1;
            end
            `CSFR_OP_ADD: begin
                wide   = {1'b0, i_alu_a} + {1'b0, i_alu_b};
                low    = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
            end
            `CSFR_OP_SUB: begin
                // Two's complement add: carry out means no borrow
                wide   = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001;
                low    = {1'b0, i_alu_a[3:0]} + {1'b0, ~i_alu_b[3:0]} + 5'h01;
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
            end
            `CSFR_OP_ROTL: begin
                // Rotate through carry, top bit leaves
                wide  = {i_alu_a, status_q[`CSFR_BIT_CARRY]};
                upd_c = 1'b1;
            end
            `CSFR_OP_ROTR: begin
                // Rotate through carry, low bit leaves
                wide  = {i_alu_a[0], status_q[`CSFR_BIT_CARRY], i_alu_a[7:1]};
                upd_c = 1'b1;
            end
            default: begin
                wide = 9'h000;
            end
        endcase
    end

    // ****************************************
    // Next status value
    // ****************************************

    // Order: store, zero-instruction, ALU flags, reset-cause events
    // Later assignments override earlier ones, so the order below
    // is the priority between events of the same cycle
    // A core store and a bus store together: the bus store is lost
    always @* begin
        status_d = status_q;
        result_d = result_q;
        // Store paths
        if (i_core_wr) begin
            // Only the six writable bits take the store
            status_d[7:5] = i_core_wdata[7:5];
            status_d[2:0] = i_core_wdata[2:0];
        end else if (apb_wr && hit_st) begin
            // Software store behaves as a flagless store
            status_d[7:5] = i_pwdata[7:5];
            status_d[2:0] = i_pwdata[2:0];
        end
        // Zero-instruction on the status register
        if (i_clr_status) begin
            status_d[7:5] = 3'h0;
            status_d[`CSFR_BIT_ZERO] = 1'b1;
        end
        // Result kept while no operation runs
        if (i_alu_op != `CSFR_OP_NONE) begin
            result_d = wide[7:0];
        end
        // Flags from the operation beat any stored value
        if (upd_z) begin
            status_d[`CSFR_BIT_ZERO] = (wide[7:0] == 8'h00);
        end
        if (upd_c) begin
            status_d[`CSFR_BIT_CARRY] = wide[8];
        end
        if (upd_dc) begin
            status_d[`CSFR_BIT_NIBBLE] = low[4];
        end
        // Time-out clears; kick or sleep sets and wins
        if (i_wdt_timeout) begin
            status_d[`CSFR_BIT_WDOG] = 1'b0;
        end
        if (i_wdt_kick || i_sleep) begin
            status_d[`CSFR_BIT_WDOG] = 1'b1;
        end
        if (i_sleep) begin
            status_d[`CSFR_BIT_SLEEP] = 1'b0;
        end
        if (i_wdt_kick) begin
            // Kick wins if both arrive together
            status_d[`CSFR_BIT_SLEEP] = 1'b1;
        end
    end

    // ****************************************
    // Status and result registers
    // ****************************************

    // Flags undefined at power-on are given zero here
    // Reset-cause bits come up as one, banks as zero
    always @(posedge i_mclk) begin
        if (i_srst) begin
            status_q <= {`CSFR_RST_BANKS, 1'b1, 1'b1, `CSFR_RST_ALUFLAGS};
            result_q <= 8'h00;
        end else begin
            status_q <= status_d;
            result_q <= result_d;
        end
    end

    // ****************************************
    // Address forming
    // ****************************************

    // Registered, so addresses lag the bank bits by one cycle
    // Direct: two bank bits above the seven-bit field
    // Indirect: one bank bit above the eight-bit pointer
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_dir_addr <= 9'h000;
            o_ind_addr <= 9'h000;
        end else begin
            o_dir_addr <= {status_q[`CSFR_BIT_DBANK_HI:`CSFR_BIT_DBANK_LO], i_dir_addr};
            o_ind_addr <= {status_q[`CSFR_BIT_IBANK], i_ind_ptr};
        end
    end

    // ****************************************
    // Shared prescaler
    // ****************************************

    // One counter serves whichever side owns it
    // Owner bit one: watchdog divided by 2^rate
    // Owner bit zero: timer divided by 2^(rate+1)
    // Step pulses last exactly one clock
    always @(posedge i_mclk) begin
        if (i_srst) begin
            pscnt_q     <= 8'h00;
            o_tmr0_step <= 1'b0;
            o_wdt_step  <= 1'b0;
        end else begin
            o_tmr0_step <= 1'b0;
            o_wdt_step  <= 1'b0;
            if (owner) begin
                // Timer passes undivided; watchdog divided
                o_tmr0_step <= i_tmr0_tick;
                if (i_wdt_tick) begin
                    pscnt_q    <= pscnt_q + 8'h01;
                    o_wdt_step <= ripe(pscnt_q, {1'b0, rate});
                end
            end else begin
                // Watchdog passes undivided; timer divided
                o_wdt_step <= i_wdt_tick;
                if (i_tmr0_tick) begin
                    pscnt_q     <= pscnt_q + 8'h01;
                    o_tmr0_step <= ripe(pscnt_q, {1'b0, rate} + 4'h1);
                end
            end
            // Reassignment restarts the count
            if (apb_wr && hit_ps) begin
                pscnt_q <= 8'h00;
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************

    // Ready one cycle into access; writes land at the done edge
    // One wait state on every transfer, reads and writes alike
    // Read data captured in the first access cycle
    // Error only for addresses outside the map
    // Writes to the result register are dropped quietly
    always @(posedge i_mclk) begin
        if (i_srst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
            pscfg_q   <= `CSFR_RST_PRESCALE;
        end else begin
            pready_q  <= apb_acc & ~pready_q;
            pslverr_q <= apb_acc & ~pready_q & ~hit_any;
            if (apb_acc && !pready_q) begin
                if (i_pwrite || !hit_any) begin
                    prdata_q <= 32'h00000000;
                end else if (hit_st) begin
                    prdata_q <= {24'h000000, status_q};
                end else if (hit_ps) begin
                    prdata_q <= {28'h0000000, pscfg_q};
                end else begin
                    prdata_q <= {24'h000000, result_q};
                end
            end
            // Configuration write at the completing edge
            if (apb_wr && hit_ps) begin
                pscfg_q <= i_pwdata[3:0];
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Copies of registers, one flop each
    // Pure renames; no logic between flop and pin
    always @* begin
        o_status     = status_q;
        o_alu_result = result_q;
        o_pready     = pready_q;
        o_prdata     = prdata_q;
        o_pslverr    = pslverr_q;
    end

endmodule

`default_nettype wire

// >>> tb/csfr_status_reg_chk.sv
// Concurrent checks on the status flag register block.
// Assumes one clock, sync active-high reset, bound to the design top.
`timescale 1ns/1ns
`default_nettype none
`include "csfr_defs.vh"

module csfr_chk (
    input wire logic       i_mclk,
    input wire logic       i_srst,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       o_pready,
    input wire logic       i_core_wr,
    input wire logic       i_clr_status,
    input wire logic [2:0] i_alu_op,
    input wire logic [7:0] i_alu_a,
    input wire logic [7:0] i_alu_b,
    input wire logic       i_wdt_kick,
    input wire logic       i_sleep,
    input wire logic       i_wdt_timeout,
    input wire logic [6:0] i_dir_addr,
    input wire logic [7:0] i_ind_ptr,
    input wire logic [8:0] o_dir_addr,
    input wire logic [8:0] o_ind_addr,
    input wire logic [7:0] o_status
);
    // ****************************************
    // Reference sums, kept apart from the design
    // ****************************************
    wire [8:0] add_s = {1'b0, i_alu_a} + {1'b0, i_alu_b};           // Full sum
    wire [4:0] add_h = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]}; // Low nibble sum
    wire [2:0] add_f = {add_s[7:0] == 8'h00, add_h[4], add_s[8]};     // Expected Z, DC, C
    wire [1:0] sub_f = {i_alu_a[3:0] >= i_alu_b[3:0], i_alu_a >= i_alu_b}; // No-borrow DC, C
    wire [8:0] dir_x = {o_status[6:5], i_dir_addr};                   // Next direct address
    wire [8:0] ind_x = {o_status[7], i_ind_ptr};                      // Next indirect address
    wire       log_z = (i_alu_a == 8'h00);                            // Logic result zero
    wire       rot_c = (i_alu_op == `CSFR_OP_ROTL) ? i_alu_a[7] : i_alu_a[0]; // Bit leaving a rotate
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // ****************************************
    // Assertions
    // ****************************************
    pready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready not in second access cycle");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready held too long");
    add_flags_a: assert property (i_alu_op == `CSFR_OP_ADD |=> o_status[2:0] == $past(add_f))
        else $error("add flags wrong");
    sub_flags_a: assert property (i_alu_op == `CSFR_OP_SUB |=> o_status[1:0] == $past(sub_f))
        else $error("sub borrow flags wrong");
    clr_bank_a: assert property (i_clr_status && !i_core_wr && i_alu_op == `CSFR_OP_NONE |=>
        o_status[7:5] == 3'h0 && o_status[2]) else $error("zero instr result wrong");
    ro_flags_a: assert property (!i_wdt_kick && !i_sleep && !i_wdt_timeout |=> $stable(o_status[4:3]))
        else $error("read-only flags moved");
    kick_set_a: assert property (i_wdt_kick |=> o_status[4:3] == 2'b11)
        else $error("kick did not set flags");
    sleep_set_a: assert property (i_sleep && !i_wdt_kick |=> o_status[4:3] == 2'b10)
        else $error("sleep flags wrong");
    tmo_clr_a: assert property (i_wdt_timeout && !i_wdt_kick && !i_sleep |=> !o_status[4])
        else $error("timeout did not clear flag");
    addr_form_a: assert property (!i_srst |=> o_dir_addr == $past(dir_x) && o_ind_addr == $past(ind_x))
        else $error("address forming wrong");
    logic_zero_a: assert property (i_alu_op == `CSFR_OP_LOGIC |=> o_status[2] == $past(log_z))
        else $error("logic zero flag wrong");
    rot_carry_a: assert property (i_alu_op == `CSFR_OP_ROTL || i_alu_op == `CSFR_OP_ROTR |=>
        o_status[0] == $past(rot_c)) else $error("rotate carry wrong");
endmodule

bind csfr_status_reg csfr_chk u_chk (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
    .i_core_wr(i_core_wr), .i_clr_status(i_clr_status), .i_alu_op(i_alu_op), .i_alu_a(i_alu_a),
    .i_alu_b(i_alu_b), .i_wdt_kick(i_wdt_kick), .i_sleep(i_sleep), .i_wdt_timeout(i_wdt_timeout),
    .i_dir_addr(i_dir_addr), .i_ind_ptr(i_ind_ptr), .o_dir_addr(o_dir_addr), .o_ind_addr(o_ind_addr),
    .o_status(o_status));
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the status flag register block.
// Assumes the design and its defines header on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "csfr_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %0h got %0h", n, e, g); end end

module tb_top;
    logic        i_mclk = 0, i_srst = 1;                          // Clock, reset
    logic        psel = 0, pen = 0, pwr = 0, cwr = 0, clr = 0;    // Strobes
    logic        tt = 0, wt = 0, er;                              // Ticks, error seen
    logic [11:0] padr = 0;                                        // Bus address
    logic [31:0] pwd = 0, rd;                                     // Bus data
    logic [7:0]  cwd = 0, a = 0, b = 0, iptr = 0;                 // Core data
    logic [6:0]  dadr = 0;                                        // Direct field
    logic [2:0]  op = 0, ev = 0;                                  // Op, {timeout,sleep,kick}
    int          n_mismatch = 0, checks = 0, nt = 0, nw = 0;      // Counters
    wire [31:0]  prdata;
    wire         pready, pslverr, ts, ws;
    wire [8:0]   da, ia;
    wire [7:0]   st, res;

    csfr_status_reg DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_core_wr(cwr), .i_core_wdata(cwd), .i_clr_status(clr), .i_alu_op(op), .i_alu_a(a), .i_alu_b(b),
        .i_wdt_kick(ev[0]), .i_sleep(ev[1]), .i_wdt_timeout(ev[2]), .i_dir_addr(dadr), .i_ind_ptr(iptr),
        .o_dir_addr(da), .o_ind_addr(ia), .o_status(st), .o_alu_result(res), .i_tmr0_tick(tt),
        .i_wdt_tick(wt), .o_tmr0_step(ts), .o_wdt_step(ws));

    // ****************************************
    // Clock and step counters
    // ****************************************
    initial begin
        forever #2 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        if (ts === 1'b1) nt++;
        if (ws === 1'b1) nw++;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks, n_mismatch);
            if (n_mismatch == 0 && checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // One APB transfer; waits for pready, bounded
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        begin
            @(posedge i_mclk); psel <= 1; pwr <= w; padr <= ad; pwd <= wd;
            @(posedge i_mclk); pen <= 1;
            n = 0;
            do begin @(posedge i_mclk); n++; end while (pready !== 1'b1 && n < 16);
            rd = prdata; er = pslverr;
            psel <= 0; pen <= 0;
            if (n >= 16) begin n_mismatch++; conclude; end
        end
    endtask
    // One core cycle; results settle after the next edge
    task cyc(input logic w, input logic [7:0] d, input logic c, input logic [2:0] o,
             input logic [7:0] x, input logic [7:0] y, input logic [2:0] e);
        begin
            @(posedge i_mclk); cwr <= w; cwd <= d; clr <= c; op <= o; a <= x; b <= y; ev <= e;
            @(posedge i_mclk); cwr <= 0; clr <= 0; op <= 0; ev <= 0; #1;
        end
    endtask
    // Tick pulses on both prescaler sources
    task ticks(input int k);
        begin
            nt = 0; nw = 0;
            repeat (k) begin @(posedge i_mclk); tt <= 1; wt <= 1; @(posedge i_mclk); tt <= 0; wt <= 0; end
            repeat (3) @(posedge i_mclk);
        end
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [7:0] xa [4];
        logic [7:0] xb [4];
        logic [7:0] sm;
        logic [2:0] o;
        logic [3:0] cf;
        logic       z, dc, c;
        xa = '{8'h0F, 8'h80, 8'h05, 8'h00};
        xb = '{8'h01, 8'h80, 8'h05, 8'h01};
        repeat (20) @(posedge i_mclk);
        i_srst <= 0;
        #1 `CHK("status reset", 8'h18, st)
        apb(0, `CSFR_ADDR_PRESCALE, 0); `CHK("prescale reset", 32'hF, rd)
        // Software store: flag bits 4:3 must not move
        apb(1, `CSFR_ADDR_STATUS, 32'hE7); apb(0, `CSFR_ADDR_STATUS, 0); `CHK("sw store", 32'hFF, rd)
        apb(0, 12'h00C, 0); `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        $display("test register bus done");
        // Store racing an add: add flags win
        cyc(1, 8'h00, 0, `CSFR_OP_ADD, 8'hFF, 8'h01, 0); `CHK("store with add", 8'h1F, st)
        cyc(1, 8'hE3, 0, `CSFR_OP_NONE, 0, 0, 0); `CHK("flagless store", 8'hFB, st)
        cyc(0, 0, 1, `CSFR_OP_NONE, 0, 0, 0); `CHK("zero instr", 8'h1F, st)
        for (int j = 0; j < 8; j++) begin
            o = j[2] ? `CSFR_OP_SUB : `CSFR_OP_ADD;
            cyc(0, 0, 0, o, xa[j[1:0]], xb[j[1:0]], 0);
            sm = j[2] ? xa[j[1:0]] - xb[j[1:0]] : xa[j[1:0]] + xb[j[1:0]];
            z = (sm == 8'h00);
            c = j[2] ? xa[j[1:0]] >= xb[j[1:0]] : ({1'b0, xa[j[1:0]]} + xb[j[1:0]]) > 9'h0FF;
            dc = j[2] ? xa[j[1:0]][3:0] >= xb[j[1:0]][3:0] : ({1'b0, xa[j[1:0]][3:0]} + xb[j[1:0]][3:0]) > 5'hF;
            `CHK("alu result", sm, res)
            `CHK("alu flags", {z, dc, c}, st[2:0])
        end
        apb(1, `CSFR_ADDR_RESULT, 32'h5A); apb(0, `CSFR_ADDR_RESULT, 0); `CHK("result reg", 32'hFF, rd)
        cyc(0, 0, 0, `CSFR_OP_LOGIC, 8'h00, 0, 0); `CHK("logic zero", 3'b100, st[2:0])
        cyc(0, 0, 0, `CSFR_OP_ROTL, 8'h81, 0, 0); `CHK("rotl", 11'h502, {st[2:0], res})
        cyc(0, 0, 0, `CSFR_OP_ROTR, 8'h02, 0, 0); `CHK("rotr", 11'h481, {st[2:0], res})
        $display("test alu done");
        cyc(0, 0, 0, 0, 0, 0, 3'h4); `CHK("timeout", 2'b01, st[4:3])
        cyc(0, 0, 0, 0, 0, 0, 3'h2); `CHK("sleep", 2'b10, st[4:3])
        cyc(0, 0, 0, 0, 0, 0, 3'h1); `CHK("kick", 2'b11, st[4:3])
        cyc(0, 0, 0, 0, 0, 0, 3'h4); cyc(0, 0, 0, 0, 0, 0, 3'h5); `CHK("kick wins", 2'b11, st[4:3])
        $display("test reset cause done");
        @(posedge i_mclk); dadr <= 7'h55; iptr <= 8'hA3;
        for (int i = 0; i < 8; i++) begin
            cyc(1, {i[2:0], 5'h0}, 0, 0, 0, 0, 0); @(posedge i_mclk); #1;
            `CHK("direct addr", {i[1:0], 7'h55}, da)
            `CHK("indirect addr", {i[2], 8'hA3}, ia)
        end
        $display("test banks done");
        for (int i = 0; i < 2; i++) begin
            cf = i ? 4'h0 : 4'h9;
            apb(1, `CSFR_ADDR_PRESCALE, {28'h0, cf}); ticks(8);
            `CHK("timer steps", cf[3] ? 8 : 8 >> (cf[2:0] + 1), nt)
            `CHK("watchdog steps", cf[3] ? 8 >> cf[2:0] : 8, nw)
        end
        $display("test prescaler done");
        @(posedge i_mclk); i_srst <= 1;
        repeat (2) @(posedge i_mclk);
        i_srst <= 0;
        #1 `CHK("second reset", 8'h18, st)
        apb(0, `CSFR_ADDR_PRESCALE, 0); `CHK("prescale reset 2", 32'hF, rd)
        $display("test second reset done");
        conclude;
    end
endmodule
`default_nettype wire
